// ---- include/lps_map.vh ----
// Constants for the low-power SDRAM command logic
//
// Overview of operation
// - Chip select high: no new command accepted
// - NOP registers nothing, disturbs nothing
// - Mode loads only when idle; A0-A11, BA
// - Activate opens row A0-A11 in bank
// - Read bursts from start column A0-A8
// - Write bursts from start column A0-A8
// - A10 selects auto precharge per command
// - Read mask high gives high-Z two clocks later
// - Write mask high leaves that byte unchanged
// - Precharge A10 high closes all banks
// - No auto precharge on full-page bursts
// - Burst terminate truncates most recent burst
// - Auto refresh uses internal row counter
// - Self refresh: ignore inputs, refresh internally
// - Deep power down drops all array contents
// - Deep power down: CKE low, CS low, HHL
// - Refresh encoding: CKE high auto, low self
// - Four masks, one per data byte
`ifndef LPS_MAP_VH
`define LPS_MAP_VH
// Command encodings on {ras_n, cas_n, we_n}
`define LPS_CMD_NOP        3'h7
`define LPS_CMD_ACTIVE     3'h3
`define LPS_CMD_READ       3'h5
`define LPS_CMD_WRITE      3'h4
`define LPS_CMD_TERMINATE  3'h6
`define LPS_CMD_PRECHARGE  3'h2
`define LPS_CMD_REFRESH    3'h1
`define LPS_CMD_LOAD_MODE  3'h0
// Mode register fields and reset values
`define LPS_MODE_BL_LSB    0
`define LPS_MODE_BL_MSB    2
`define LPS_MODE_CL_LSB    4
`define LPS_MODE_CL_MSB    6
`define LPS_MODE_WB_BIT    9
`define LPS_MODE_RESET     12'h020
`define LPS_EXT_RESET      12'h000
`define LPS_BA_EXT_MODE    2'h2
`define LPS_BL_FULL_PAGE   3'h7
`define LPS_AUTO_PRE_BIT   10
// Modes of the device
`define LPS_ST_NORMAL      2'h0
`define LPS_ST_SELF_REF    2'h1
`define LPS_ST_DEEP_PD     2'h2
// Timing
`define LPS_CLK_MHZ            100
`define LPS_ROW_ACTIVE_NS      50
`define LPS_ROW_ACTIVE_CYC     ((`LPS_ROW_ACTIVE_NS*`LPS_CLK_MHZ+999)/1000)
`define LPS_REF_INTERVAL_PS    7812500
`define LPS_REF_INTERVAL_CYC   (`LPS_REF_INTERVAL_PS*`LPS_CLK_MHZ/1000000)
// Array model size (bank, low row bits, column)
`define LPS_ROW_BITS       2
`define LPS_COL_BITS       9
`define LPS_IDX_BITS       13
`define LPS_WORDS          8192
`define LPS_REF_ROW_BITS   13
`endif

// ---- rtl/lps_command_logic.v ----
// Command decode, bank tracking, burst engine and array of the SDRAM
`timescale 1ns/1ps
`include "lps_map.vh"
module lps_command_logic (
  input  wire        clk,
  input  wire        reset,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [1:0]  ba,
  input  wire [11:0] addr,
  input  wire [3:0]  dqm,
  input  wire [31:0] dq_in,
  output reg  [31:0] dq_out,
  output reg  [3:0]  dq_oe,
  output reg  [3:0]  bank_open,
  output reg  [1:0]  power_state,
  output reg  [12:0] refresh_row,
  output reg  [11:0] mode_reg,
  output reg  [11:0] ext_mode_reg
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [31:0] mem [0:`LPS_WORDS-1];       // Array model
  reg  [`LPS_WORDS-1:0] word_valid;       // Word holds retained data
  reg  [11:0] open_row [0:3];             // Open row per bank
  reg         burst_on;                   // Burst in progress
  reg         burst_wr;                   // Burst is a write
  reg  [1:0]  burst_bank;                 // Bank of the burst
  reg  [8:0]  burst_col;                  // Next column of the burst
  reg  [9:0]  burst_left;                 // Words still to move
  reg         burst_pre;                  // Precharge at burst end
  reg  [31:0] rd_a;                       // Read pipe stage one
  reg         rd_a_v;
  reg  [31:0] rd_b;                       // Read pipe stage two
  reg         rd_b_v;
  reg  [3:0]  dqm_d1;                     // Read mask delayed one clock
  reg  [15:0] sr_count;                   // Self refresh time counter
  reg  [15:0] sr_tick;                    // Internal refresh interval
  reg  [9:0]  next_len;
  reg  [8:0]  next_mask;
  reg  [8:0]  next_col;

  wire [2:0]  cmd = {ras_n, cas_n, we_n};
  wire        sel = !cs_n && (power_state == `LPS_ST_NORMAL);
  wire        run = sel && cke;           // Clock-enabled command slot
  // A NOP matches none of these decodes and starts nothing
  wire        is_act  = run && cmd == `LPS_CMD_ACTIVE;
  wire        is_rd   = run && cmd == `LPS_CMD_READ && bank_open[ba];
  wire        is_wr   = run && cmd == `LPS_CMD_WRITE && bank_open[ba];
  wire        is_bst  = run && cmd == `LPS_CMD_TERMINATE;
  wire        is_pre  = run && cmd == `LPS_CMD_PRECHARGE;
  wire        is_aref = run && cmd == `LPS_CMD_REFRESH;
  wire        is_sref = sel && !cke && cmd == `LPS_CMD_REFRESH &&
                        bank_open == 4'h0;
  wire        is_deep_pd = sel && !cke &&
                           cmd == `LPS_CMD_TERMINATE;
  wire        is_lmr  = run && cmd == `LPS_CMD_LOAD_MODE &&
                        bank_open == 4'h0 && !burst_on;
  wire [2:0]  bl_code = mode_reg[`LPS_MODE_BL_MSB:`LPS_MODE_BL_LSB];
  wire        full_pg = bl_code == `LPS_BL_FULL_PAGE;
  wire        single_wr = mode_reg[`LPS_MODE_WB_BIT];
  wire        new_acc = is_rd || is_wr;
  wire        last = burst_on && burst_left == 10'h001;
  wire [8:0]  cur_col = new_acc ? addr[8:0] : burst_col;
  wire [1:0]  cur_bank = new_acc ? ba : burst_bank;
  wire [`LPS_IDX_BITS-1:0] idx =
    {cur_bank, open_row[cur_bank][`LPS_ROW_BITS-1:0], cur_col};
  wire        do_wr = is_wr || (burst_on && burst_wr && !is_bst && !new_acc);
  wire        do_rd = is_rd || (burst_on && !burst_wr && !is_bst && !new_acc);

  //////////////////////////////////////////////////////////////////////////
  // Burst length and wrap mask for the current mode
  always @* begin
    next_len  = 10'h001;
    next_mask = 9'h000;
    case (bl_code)
      3'h0: begin
        next_len  = 10'h001;
        next_mask = 9'h000;
      end
      3'h1: begin
        next_len  = 10'h002;
        next_mask = 9'h001;
      end
      3'h2: begin
        next_len  = 10'h004;
        next_mask = 9'h003;
      end
      3'h3: begin
        next_len  = 10'h008;
        next_mask = 9'h007;
      end
      3'h7: begin
        next_len  = 10'h200;
        next_mask = 9'h1FF;
      end
      default: begin
        next_len  = 10'h001;
        next_mask = 9'h000;
      end
    endcase
    if (is_wr && single_wr) begin
      // Single-location writes regardless of programmed length
      next_len = 10'h001;
    end
    next_col = (cur_col & ~next_mask) |
               ((cur_col + 9'h001) & next_mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-bank open state and row, one instance per bank
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : bank_track
      wire auto_close = last && burst_pre && burst_bank == g;
      // Single-word access with auto precharge closes on its own edge
      wire imm_close  = new_acc && ba == g && addr[`LPS_AUTO_PRE_BIT] &&
                        next_len == 10'h001 && !full_pg;
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          bank_open[g] <= 1'b0;
          open_row[g]  <= 12'h000;
        end else if (power_state == `LPS_ST_DEEP_PD) begin
          bank_open[g] <= 1'b0;
        end else if (is_act && ba == g) begin
          bank_open[g] <= 1'b1;
          open_row[g]  <= addr;
        end else if (is_pre && (addr[`LPS_AUTO_PRE_BIT] || ba == g)) begin
          bank_open[g] <= 1'b0;
        end else if (imm_close) begin
          bank_open[g] <= 1'b0;
        end else if (auto_close && !new_acc && !is_bst) begin
          bank_open[g] <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Burst engine; a new access or a terminate ends the running burst
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      burst_on   <= 1'b0;
      burst_wr   <= 1'b0;
      burst_bank <= 2'h0;
      burst_col  <= 9'h000;
      burst_left <= 10'h000;
      burst_pre  <= 1'b0;
    end else if (power_state != `LPS_ST_NORMAL || is_bst) begin
      burst_on <= 1'b0;
    end else if (new_acc) begin
      burst_on   <= next_len != 10'h001;
      burst_wr   <= is_wr;
      burst_bank <= ba;
      burst_col  <= next_col;
      burst_left <= next_len - 10'h001;
      burst_pre  <= addr[`LPS_AUTO_PRE_BIT] && !full_pg;
    end else if (burst_on) begin
      burst_col  <= next_col;
      burst_left <= burst_left - 10'h001;
      // Full page wraps and runs until terminated
      burst_on   <= full_pg || !last;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Array write with byte masks and word validity
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : lane_wr
      always @(posedge clk) begin
        if (do_wr && !dqm[b]) begin
          mem[idx][8*b+7:8*b] <= dq_in[8*b+7:8*b];
        end else if (do_wr && !word_valid[idx]) begin
          // Masked lane of a dropped word reads back as zero
          mem[idx][8*b+7:8*b] <= 8'h00;
        end
      end
    end
  endgenerate

  // Validity of stored words; entering deep power down drops them all
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      word_valid <= {`LPS_WORDS{1'b0}};
    end else if (is_deep_pd) begin
      word_valid <= {`LPS_WORDS{1'b0}};
    end else if (do_wr) begin
      word_valid[idx] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read pipe: CAS latency two or three, masks act two clocks on
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_a   <= 32'h00000000;
      rd_a_v <= 1'b0;
      rd_b   <= 32'h00000000;
      rd_b_v <= 1'b0;
      dqm_d1 <= 4'hF;
      dq_out <= 32'h00000000;
      dq_oe  <= 4'h0;
    end else begin
      rd_a   <= word_valid[idx] ? mem[idx] : 32'h00000000;
      rd_a_v <= do_rd && power_state == `LPS_ST_NORMAL;
      rd_b   <= rd_a;
      rd_b_v <= rd_a_v;
      dqm_d1 <= dqm;
      if (mode_reg[`LPS_MODE_CL_MSB:`LPS_MODE_CL_LSB] == 3'h3) begin
        dq_out <= rd_b;
        dq_oe  <= {4{rd_b_v}} & ~dqm_d1;
      end else begin
        dq_out <= rd_a;
        dq_oe  <= {4{rd_a_v}} & ~dqm_d1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode registers, refresh counter and power states
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg     <= `LPS_MODE_RESET;
      ext_mode_reg <= `LPS_EXT_RESET;
      refresh_row  <= 13'h0000;
      power_state  <= `LPS_ST_NORMAL;
      sr_count     <= 16'h0000;
      sr_tick      <= 16'h0000;
    end else begin
      case (power_state)
        `LPS_ST_NORMAL: begin
          sr_count <= 16'h0000;
          sr_tick  <= 16'h0000;
          if (is_lmr && ba == `LPS_BA_EXT_MODE) begin
            ext_mode_reg <= addr;
          end else if (is_lmr) begin
            mode_reg <= addr;
          end
          if (is_aref) begin
            refresh_row <= refresh_row + 13'h0001;
          end
          if (is_sref) begin
            power_state <= `LPS_ST_SELF_REF;
          end else if (is_deep_pd) begin
            power_state <= `LPS_ST_DEEP_PD;
          end
        end
        `LPS_ST_SELF_REF: begin
          // Internal clocking: periodic refresh of the next row
          if (sr_tick == `LPS_REF_INTERVAL_CYC - 1) begin
            sr_tick     <= 16'h0000;
            refresh_row <= refresh_row + 13'h0001;
          end else begin
            sr_tick <= sr_tick + 16'h0001;
          end
          if (sr_count != 16'hFFFF) begin
            sr_count <= sr_count + 16'h0001;
          end
          if (cke && sr_count >= `LPS_ROW_ACTIVE_CYC - 1) begin
            power_state <= `LPS_ST_NORMAL;
          end
        end
        `LPS_ST_DEEP_PD: begin
          // Leaving needs a full initialization from the controller
          if (cke) begin
            power_state  <= `LPS_ST_NORMAL;
            mode_reg     <= `LPS_MODE_RESET;
            ext_mode_reg <= `LPS_EXT_RESET;
          end
        end
        default: begin
          power_state <= `LPS_ST_NORMAL;
        end
      endcase
    end
  end

endmodule // lps_command_logic

// ---- verification/lps_chk_asserts.sv ----
// Assertion checker on the SDRAM command logic ports
`timescale 1ns/1ps
module lps_chk (
  input wire        clk,
  input wire        reset,
  input wire        cke,
  input wire        cs_n,
  input wire        ras_n,
  input wire        cas_n,
  input wire        we_n,
  input wire [1:0]  ba,
  input wire [11:0] addr,
  input wire [3:0]  dqm,
  input wire [3:0]  dq_oe,
  input wire [3:0]  bank_open,
  input wire [1:0]  power_state,
  input wire [11:0] mode_reg
);
  //////////////////////////////////////////////////////////////////////////
  // Command code and an awake, selected device
  wire [2:0] c  = {ras_n, cas_n, we_n};
  wire       go = !cs_n && cke && power_state == 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Self refresh entry with all banks idle
  sequence s_sr;
    !cs_n && !cke && c == 3'h1 && bank_open == 4'h0 && power_state == 2'h0;
  endsequence
  property p_desel; cs_n |=> (bank_open & ~$past(bank_open)) == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("opened unselected");
  property p_mode; go && c == 3'h0 && ba == 2'h0 && bank_open == 4'h0 &&
    dq_oe == 4'h0 |=> mode_reg == $past(addr); endproperty
  a_mode: assert property (p_mode) else $error("mode not loaded");
  property p_act; go && c == 3'h3 |=> bank_open[$past(ba)]; endproperty
  a_act: assert property (p_act) else $error("row not opened");
  property p_ap; go && c == 3'h5 && addr[10] && ba == 2'h1 &&
    bank_open == 4'h2 && mode_reg[2:0] == 3'h0 |-> ##[1:3] bank_open == 4'h0;
  endproperty
  a_ap: assert property (p_ap) else $error("no auto close");
  property p_mask; dq_oe != 4'h0 |-> (dq_oe & $past(dqm, 2)) == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("masked lane driven");
  property p_pre; go && c == 3'h2 && addr[10] |=> bank_open == 4'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("banks left open");
  property p_sr; s_sr |=> (power_state == 2'h1)[*5]; endproperty
  a_sr: assert property (p_sr) else $error("self refresh short");
  property p_deep_pd; !cs_n && !cke && c == 3'h6 && power_state == 2'h0
    |=> power_state == 2'h2; endproperty
  a_deep_pd: assert property (p_deep_pd) else $error("not entered");
endmodule // lps_chk
bind lps_command_logic lps_chk u_chk (.clk(clk), .reset(reset),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .ba(ba), .addr(addr), .dqm(dqm), .dq_oe(dq_oe), .bank_open(bank_open),
  .power_state(power_state), .mode_reg(mode_reg));

// ---- verification/lps_ctl.sv ----
// Controller model that issues commands to the SDRAM
`timescale 1ns/1ps
module lps_ctl #(
  parameter mode_load_delay         = 2, // Cycles after a mode load
  parameter precharge_period        = 2, // Cycles after a precharge
  parameter self_refresh_exit_delay = 4  // NOP cycles after wake
) (
  input  wire        clk,
  output reg         cke,
  output reg         cs_n,
  output reg  [2:0]  cmd,
  output reg  [1:0]  ba,
  output reg  [11:0] addr,
  output reg  [3:0]  dqm,
  output reg  [31:0] dq_in
);
  //////////////////////////////////////////////////////////////////////////
  // Deselected and idle at time zero
  initial {cke, cs_n, cmd, ba, addr, dqm, dq_in} = {2'b11, 3'h7, 50'h0};
  // One command with s = {cke, cs_n}, then a selected NOP with address and data inverted
  task go(input [1:0] s, input [2:0] c, input [1:0] b, input [11:0] a,
          input [3:0] m, input [31:0] d);
    begin
      @(posedge clk);
      {cke, cs_n, cmd, ba, addr, dqm, dq_in} <= {s, c, b, a, m, d};
      @(posedge clk);
      {cs_n, cmd, addr, dqm, dq_in} <= {1'b0, 3'h7, ~a, 4'h0, ~d};
      if (c == 3'h0) repeat (mode_load_delay) @(posedge clk);
      if (c == 3'h2) repeat (precharge_period) @(posedge clk);
      #1;
    end
  endtask
  // Raise clock enable, then NOPs only
  task wake;
    begin
      @(posedge clk);
      cke <= 1'b1;
      repeat (self_refresh_exit_delay) @(posedge clk);
      #1;
    end
  endtask
  // Close all banks, two refreshes, base mode CL2 BL1
  task init;
    begin
      go(2'b10, 3'h2, 2'h0, 12'h400, 4'h0, 32'h0);
      go(2'b10, 3'h1, 2'h0, 12'h000, 4'h0, 32'h0);
      go(2'b10, 3'h1, 2'h0, 12'h000, 4'h0, 32'h0);
      go(2'b10, 3'h0, 2'h0, 12'h020, 4'h0, 32'h0);
    end
  endtask
endmodule // lps_ctl

// ---- verification/tb_lps_command_logic.sv ----
// Self-checking bench for the SDRAM command logic
`timescale 1ns/1ps
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_lps_command_logic;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  wire        cke, cs_n;
  wire [2:0]  cmd;
  wire [1:0]  ba, power_state;
  wire [11:0] addr, mode_reg, ext_mode_reg;
  wire [3:0]  dqm, dq_oe, bank_open;
  wire [31:0] dq_in, dq_out;
  wire [12:0] refresh_row;
  int         failures = 0;
  int         tests_run = 0;
  //////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 clk = ~clk;
  lps_ctl ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_in(dq_in));
  lps_command_logic dut (.clk(clk), .reset(reset), .cke(cke),
    .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .bank_open(bank_open), .power_state(power_state),
    .refresh_row(refresh_row), .mode_reg(mode_reg),
    .ext_mode_reg(ext_mode_reg));
  // Read one word, check driven lanes and unmasked data
  task rd(input [1:0] b, input [11:0] a, input [3:0] m, input [31:0] e);
    logic [31:0] k;
    begin
      k = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
      ctl.go(2'b10, 3'h5, b, a, m, 32'h0);
      @(posedge clk);
      #1;
      `CK(dq_oe, ~m)
      `CK(dq_out & k, e)
    end
  endtask
  // Start-up and both mode loads
  task t_boot;
    begin
      ctl.init;
      `CK(mode_reg, 12'h020)
      `CK(refresh_row, 13'h0002)
      ctl.go(2'b10, 3'h0, 2'h2, 12'h0A5, 4'h0, 32'h0);
      `CK(ext_mode_reg, 12'h0A5)
      `CK(mode_reg, 12'h020)
      $display("boot done");
    end
  endtask
  // Open a row, deselect, masked writes and reads
  task t_rw;
    begin
      ctl.go(2'b10, 3'h3, 2'h1, 12'h123, 4'h0, 32'h0);
      `CK(bank_open, 4'h2)
      ctl.go(2'b11, 3'h3, 2'h2, 12'h001, 4'h0, 32'h0);
      `CK(bank_open, 4'h2)
      ctl.go(2'b10, 3'h4, 2'h1, 12'h005, 4'h0, 32'h11223344);
      ctl.go(2'b10, 3'h4, 2'h1, 12'h005, 4'h5, 32'hAABBCCDD);
      rd(2'h1, 12'h005, 4'h2, 32'hAA220044);
      rd(2'h1, 12'h004, 4'h0, 32'h00000000);
      `CK(bank_open, 4'h2)
      $display("rw done");
    end
  endtask
  // Auto close, full page, terminate, precharge one and all
  task t_pre;
    begin
      rd(2'h1, 12'h405, 4'h0, 32'hAA22CC44);
      #20;
      `CK(bank_open, 4'h0)
      ctl.go(2'b10, 3'h0, 2'h0, 12'h027, 4'h0, 32'h0);
      ctl.go(2'b10, 3'h3, 2'h1, 12'h123, 4'h0, 32'h0);
      rd(2'h1, 12'h405, 4'h0, 32'hAA22CC44);
      #30;
      `CK(bank_open, 4'h2)
      ctl.go(2'b10, 3'h6, 2'h0, 12'h000, 4'h0, 32'h0);
      #30;
      `CK(dq_oe, 4'h0)
      ctl.go(2'b10, 3'h3, 2'h0, 12'h123, 4'h0, 32'h0);
      ctl.go(2'b10, 3'h2, 2'h0, 12'h000, 4'h0, 32'h0);
      `CK(bank_open, 4'h2)
      ctl.go(2'b10, 3'h2, 2'h3, 12'h400, 4'h0, 32'h0);
      `CK(bank_open, 4'h0)
      ctl.go(2'b10, 3'h0, 2'h0, 12'h020, 4'h0, 32'h0);
      $display("precharge done");
    end
  endtask
  // Self refresh keeps data and ignores commands
  task t_sr;
    begin
      ctl.go(2'b00, 3'h1, 2'h0, 12'h000, 4'h0, 32'h0);
      `CK(power_state, 2'h1)
      ctl.go(2'b00, 3'h3, 2'h0, 12'h123, 4'h0, 32'h0);
      ctl.wake;
      `CK(power_state, 2'h0)
      `CK(bank_open, 4'h0)
      ctl.go(2'b10, 3'h3, 2'h1, 12'h123, 4'h0, 32'h0);
      rd(2'h1, 12'h005, 4'h0, 32'hAA22CC44);
      ctl.go(2'b10, 3'h2, 2'h1, 12'h000, 4'h0, 32'h0);
      $display("self refresh done");
    end
  endtask
  // Deep power down loses contents and mode settings
  task t_deep_pd;
    begin
      ctl.go(2'b00, 3'h6, 2'h0, 12'h000, 4'h0, 32'h0);
      `CK(power_state, 2'h2)
      ctl.wake;
      `CK(ext_mode_reg, 12'h000)
      #82000;
      ctl.init;
      ctl.go(2'b10, 3'h3, 2'h1, 12'h123, 4'h0, 32'h0);
      rd(2'h1, 12'h005, 4'h0, 32'h00000000);
      $display("deep power down done");
    end
  endtask
  // CAS latency three, burst of four with wrap, write burst
  task t_burst;
    begin
      ctl.go(2'b10, 3'h2, 2'h0, 12'h400, 4'h0, 32'h0);
      ctl.go(2'b10, 3'h0, 2'h0, 12'h032, 4'h0, 32'h0);
      ctl.go(2'b10, 3'h3, 2'h2, 12'h000, 4'h0, 32'h0);
      ctl.go(2'b10, 3'h4, 2'h2, 12'h005, 4'h0, 32'h5A5A0F0F);
      repeat (3) @(posedge clk);
      ctl.go(2'b10, 3'h5, 2'h2, 12'h006, 4'h0, 32'h0);
      @(posedge clk);
      #1;
      `CK(dq_oe, 4'h0)
      repeat (3) @(posedge clk);
      #1;
      `CK(dq_out, 32'hA5A5F0F0)
      @(posedge clk);
      #1;
      `CK(dq_out, 32'h5A5A0F0F)
      `CK(dq_oe, 4'hF)
      $display("burst done");
    end
  endtask
  // Counts, verdict, end of run
  task results;
    begin
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_boot;
    t_rw;
    t_pre;
    t_sr;
    t_deep_pd;
    t_burst;
    results;
  end
  // Watchdog: the scenarios need about 8300 cycles
  initial begin
    repeat (12000) @(posedge clk);
    failures++;
    results;
  end
endmodule // tb_lps_command_logic
